// ===== rtl/bfi_pkg.sv
// Constants shared by the reader buffer port and interrupt status logic
// What this block does
// - Fill counter readable, eight bits, read only
// - Large mode adds two upper count bits
// - Data port write increments, read decrements count
// - Address holds on data port, else advances
// - Data port pushes and pops bytes in order
// - Bit seven selects set or clear action
// - Bit seven is write only, never stored
// - High threshold live latches bit six
// - Low threshold live latches bit five
// - Self ended command sets idle flag
// - Unknown command forces idle, sets flag
// - Host idle command sets no flag
// - Last transmitted bit sets bit three
// - Receive stream end sets bit two
// - Any listed fault sets bit one
// - Receive frame start sets bit zero
// - Status at address six, resets to zero
// - High live when free space at or under level
// - Low live when count at or under level
// - Config bit selects 255 or 512 depth
// - Flush empties buffer, bit reads zero
package bfi_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_CFG = 8'h02;
    localparam logic [7:0] ADDR_WL = 8'h03;
    localparam logic [7:0] ADDR_FILL = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h05;
    localparam logic [7:0] ADDR_STATUS = 8'h06;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CFG_DEPTH_BIT = 7;
    localparam int CFG_FLUSH_BIT = 4;
    localparam int CFG_WLEXT_BIT = 2;
    localparam int IRQ_SET_BIT = 7;
    // ****************************************
    // Sizes and reset values
    // ****************************************
    localparam int BYTE_W = 8;
    localparam int CNT_W = 10;
    localparam int MEM_AW = 9;
    localparam int MEM_DEPTH = 512;
    localparam int RX_FIFO_DEPTH = 16;
    localparam logic [CNT_W-1:0] DEPTH_SMALL = 10'h0ff;
    localparam logic [CNT_W-1:0] DEPTH_LARGE = 10'h200;
    localparam logic [CNT_W-1:0] FILL_RESET = 10'h000;
    localparam logic [6:0] IRQ_RESET = 7'h00;
    localparam logic CFG_DEPTH_RESET = 1'b0;
    localparam logic [8:0] WL_RESET = 9'h000;
    localparam logic [7:0] ADDR_RESET = 8'h00;
endpackage : bfi_pkg

// ===== rtl/bfi_mem.sv
// Byte buffer storage with registered read data
`timescale 1ns/100ps
module bfi_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 512,
    parameter int AW = 9
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    // No reset on the array so it maps to block memory
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : bfi_mem

// ===== rtl/bfi_fifo.sv
// Small receive-side FIFO with valid and ready on both sides
`timescale 1ns/100ps
module bfi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } bfi_fifo_t;

    bfi_fifo_t r_reg;
    bfi_fifo_t r_next;
    logic full;
    logic empty;

    assign empty = r_reg.wp == r_reg.rp;
    assign full = (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]) && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = r_reg.mem[r_reg.rp[AW-1:0]];

    always_comb begin
        r_next = r_reg;
        if (in_valid && !full) begin
            r_next.mem[r_reg.wp[AW-1:0]] = in_data;
            r_next.wp = r_reg.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            r_next.rp = r_reg.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule : bfi_fifo

// ===== rtl/bfi_core.sv
// Buffer data port, fill counter, threshold flags and interrupt status
`timescale 1ns/100ps
module bfi_core (
    input wire logic clk,
    input wire logic resetn,
    input wire logic acc_start,
    input wire logic [7:0] acc_addr,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [7:0] acc_wdata,
    output logic [7:0] acc_rdata,
    output logic acc_rdone,
    input wire logic rx_valid,
    input wire logic [bfi_pkg::BYTE_W-1:0] rx_data,
    output logic rx_ready,
    input wire logic cmd_self_done,
    input wire logic cmd_unknown,
    output logic cmd_force_idle,
    input wire logic tx_last_bit,
    input wire logic rx_frame_end,
    input wire logic rx_frame_start,
    input wire logic buffer_write_fault,
    input wire logic buffer_overrun_fault,
    input wire logic protocol_fault,
    input wire logic missing_payload_fault,
    input wire logic integrity_fault,
    output logic [6:0] interrupt_status_zero,
    output logic high_threshold_live,
    output logic low_threshold_live
);
    import bfi_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic [CNT_W-1:0] cnt;
        logic [MEM_AW-1:0] wp;
        logic [MEM_AW-1:0] rp;
        logic depth_sel;
        logic [8:0] wl;
        logic [6:0] irq;
        logic s1_pend;
        logic s1_data;
        logic [7:0] s1_val;
        logic [7:0] rdata;
        logic rdone;
        logic force_idle;
    } bfi_core_t;

    bfi_core_t r_reg;
    bfi_core_t r_next;

    logic [7:0] mem_q;
    logic mem_we;
    logic [7:0] mem_wd;
    logic fifo_valid;
    logic fifo_ready;
    logic [7:0] fifo_data;
    logic [CNT_W-1:0] depth;
    logic [CNT_W-1:0] wl_eff;
    logic full;
    logic empty;
    logic data_acc;
    logic host_push;
    logic host_pop;
    logic overrun;
    logic flush;
    logic rx_take;
    logic [6:0] events;
    logic [CNT_W-1:0] cnt_w;
    logic [7:0] addr_w;
    logic [6:0] irq_w;

    // Count step used for the pointer-free fill count arithmetic
    function automatic logic [CNT_W-1:0] bfi_step(
        input logic [CNT_W-1:0] c,
        input logic up,
        input logic down
    );
        logic [CNT_W-1:0] v;
        v = c;
        if (up && !down) begin
            v = c + 1'b1;
        end else if (down && !up) begin
            v = c - 1'b1;
        end
        return v;
    endfunction : bfi_step

    // ****************************************
    // Storage and receive path
    // ****************************************
    bfi_mem #(
        .WIDTH(BYTE_W),
        .DEPTH(MEM_DEPTH),
        .AW(MEM_AW)
    ) u_mem (
        .clk(clk),
        .we(mem_we),
        .waddr(r_reg.wp),
        .wdata(mem_wd),
        .raddr(r_reg.rp),
        .rdata(mem_q)
    );

    // Back-pressure: host traffic on the buffer stalls the drain
    bfi_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data(rx_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    // ****************************************
    // Buffer level decode
    // ****************************************
    // depth from config
    assign depth = r_reg.depth_sel ? DEPTH_SMALL : DEPTH_LARGE;
    // Level extension bit only counts in large mode
    assign wl_eff = r_reg.depth_sel ? {2'b00, r_reg.wl[7:0]}
        : {1'b0, r_reg.wl};
    assign full = r_reg.cnt >= depth;
    assign empty = r_reg.cnt == FILL_RESET;
    assign high_threshold_live = (depth - r_reg.cnt) <= wl_eff;
    assign low_threshold_live = r_reg.cnt <= wl_eff;

    assign data_acc = acc_valid && r_reg.addr == ADDR_DATA;
    assign host_push = data_acc && acc_write && !full;
    assign host_pop = data_acc && !acc_write && !empty;
    assign overrun = data_acc && acc_write && full;
    assign flush = acc_valid && acc_write && r_reg.addr == ADDR_CFG
        && acc_wdata[CFG_FLUSH_BIT];
    assign fifo_ready = !data_acc && !full && !flush;
    assign rx_take = fifo_valid && fifo_ready;
    assign mem_we = host_push || rx_take;
    assign mem_wd = host_push ? acc_wdata : fifo_data;

    assign events[1] = buffer_write_fault || buffer_overrun_fault
        || protocol_fault || missing_payload_fault || integrity_fault
        || overrun;
    assign events[6] = high_threshold_live;
    assign events[5] = low_threshold_live;
    // only self end or unknown count
    assign events[4] = cmd_self_done || cmd_unknown;
    assign events[3] = tx_last_bit;
    // end of stream, good or bad
    assign events[2] = rx_frame_end;
    assign events[0] = rx_frame_start;

    assign cnt_w = r_reg.cnt;
    assign addr_w = r_reg.addr;
    assign irq_w = r_reg.irq;
    assign acc_rdata = r_reg.rdata;
    assign acc_rdone = r_reg.rdone;
    assign cmd_force_idle = r_reg.force_idle;
    assign interrupt_status_zero = r_reg.irq;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        r_next = r_reg;
        r_next.rdone = r_reg.s1_pend;
        if (r_reg.s1_pend) begin
            r_next.rdata = r_reg.s1_data ? mem_q : r_reg.s1_val;
        end
        r_next.s1_pend = 1'b0;
        r_next.force_idle = cmd_unknown;
        if (acc_start) begin
            r_next.addr = acc_addr;
        end else if (acc_valid && r_reg.addr != ADDR_DATA) begin
            r_next.addr = r_reg.addr + 8'h01;
        end
        if (mem_we) begin
            r_next.wp = r_reg.wp + 1'b1;
        end
        if (host_pop) begin
            r_next.rp = r_reg.rp + 1'b1;
        end
        r_next.cnt = bfi_step(r_reg.cnt, mem_we, host_pop);
        if (flush) begin
            r_next.wp = '0;
            r_next.rp = '0;
            r_next.cnt = FILL_RESET;
        end
        if (acc_valid && !acc_write) begin
            r_next.s1_pend = 1'b1;
            r_next.s1_data = r_reg.addr == ADDR_DATA;
            unique case (r_reg.addr)
                // upper count bits in large mode
                ADDR_CFG: r_next.s1_val = {r_reg.depth_sel,
                    high_threshold_live, low_threshold_live, 2'b00,
                    r_reg.wl[8],
                    r_reg.depth_sel ? 2'b00 : r_reg.cnt[9:8]};
                ADDR_WL: r_next.s1_val = r_reg.wl[7:0];
                ADDR_FILL: r_next.s1_val = r_reg.cnt[7:0];
                ADDR_STATUS: r_next.s1_val = {1'b0, r_reg.irq};
                default: r_next.s1_val = 8'h00;
            endcase
        end
        if (acc_valid && acc_write) begin
            unique case (r_reg.addr)
                ADDR_CFG: begin
                    r_next.depth_sel = acc_wdata[CFG_DEPTH_BIT];
                    r_next.wl[8] = acc_wdata[CFG_WLEXT_BIT];
                end
                ADDR_WL: r_next.wl[7:0] = acc_wdata;
                // set or clear by bit seven
                ADDR_STATUS: begin
                    if (acc_wdata[IRQ_SET_BIT]) begin
                        r_next.irq = r_reg.irq | acc_wdata[6:0];
                    end else begin
                        r_next.irq = r_reg.irq & ~acc_wdata[6:0];
                    end
                end
                default: r_next.addr = r_next.addr;
            endcase
        end
        r_next.irq = r_next.irq | events;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
            r_reg.addr <= ADDR_RESET;
            r_reg.cnt <= FILL_RESET;
            r_reg.depth_sel <= CFG_DEPTH_RESET;
            r_reg.wl <= WL_RESET;
            r_reg.irq <= IRQ_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_FILL_READ: assert property (@(posedge clk) disable iff (!resetn)
        acc_valid && !acc_write && addr_w == ADDR_FILL |->
        ##2 acc_rdone && acc_rdata == $past(cnt_w[7:0], 2))
        else $error("fill count readback wrong");
    AST_PUSH_COUNT: assert property (@(posedge clk)
        disable iff (!resetn)
        host_push && !flush |=> cnt_w == $past(cnt_w) + 10'h001)
        else $error("push did not raise count");
    AST_POP_COUNT: assert property (@(posedge clk) disable iff (!resetn)
        host_pop && !rx_take |=> cnt_w == $past(cnt_w) - 10'h001)
        else $error("pop did not lower count");
    AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        data_acc && !acc_start |=> addr_w == ADDR_DATA)
        else $error("address moved on data port");
    AST_ADDR_STEP: assert property (@(posedge clk) disable iff (!resetn)
        acc_valid && !acc_start && addr_w != ADDR_DATA
        |=> addr_w == $past(addr_w) + 8'h01)
        else $error("address did not advance");
    AST_IRQ_SET: assert property (@(posedge clk) disable iff (!resetn)
        acc_valid && acc_write && addr_w == ADDR_STATUS && acc_wdata[7]
        |=> (irq_w & $past(acc_wdata[6:0])) == $past(acc_wdata[6:0]))
        else $error("set write did not set");
    // Bits raised by a same-cycle event stay set, so they are masked
    AST_IRQ_CLR: assert property (@(posedge clk) disable iff (!resetn)
        acc_valid && acc_write && addr_w == ADDR_STATUS && !acc_wdata[7]
        |=> (irq_w & $past(acc_wdata[6:0]) & ~$past(events)) == 7'h00)
        else $error("clear write did not clear");
    AST_BIT7_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        acc_valid && !acc_write && addr_w == ADDR_STATUS
        |-> ##2 acc_rdone && !acc_rdata[7])
        else $error("bit seven read back set");
    AST_HI_LATCH: assert property (@(posedge clk) disable iff (!resetn)
        high_threshold_live |=> irq_w[6])
        else $error("high flag not latched");
    AST_LO_LATCH: assert property (@(posedge clk) disable iff (!resetn)
        low_threshold_live |=> irq_w[5])
        else $error("low flag not latched");
    AST_UNKNOWN: assert property (@(posedge clk) disable iff (!resetn)
        cmd_unknown |=> cmd_force_idle && irq_w[4])
        else $error("unknown command not handled");
    AST_ERR_FLAG: assert property (@(posedge clk) disable iff (!resetn)
        protocol_fault || integrity_fault |=> irq_w[1])
        else $error("fault flag not set");
    AST_FLUSH: assert property (@(posedge clk) disable iff (!resetn)
        flush |=> cnt_w == FILL_RESET)
        else $error("flush left bytes");
    AST_STICKY: assert property (@(posedge clk) disable iff (!resetn)
        irq_w[3] && !(acc_valid && acc_write && addr_w == ADDR_STATUS)
        |=> irq_w[3])
        else $error("flag dropped without clear");
endmodule : bfi_core

// ===== verification/bfi_rx_source.sv
// Receiver side model that streams bytes into the block
`timescale 1ns/100ps
module bfi_rx_source (
    input wire logic clk,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    import bfi_pkg::*;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    // Byte i carries the low eight bits of i; held until ready is seen, so a full FIFO
    // stalls the stream instead of losing bytes
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_data = i[7:0];
            while (rx_ready !== 1'b1) @(negedge clk);
        end
        @(negedge clk);
        rx_valid = 1'b0;
        // Released line shows the inverse, never a stale byte
        rx_data = ~rx_data;
    endtask : send
endmodule : bfi_rx_source

// ===== verification/fifo_port_and_irq_status_bench.sv
// Self-checking bench for the buffer port and interrupt status block
`timescale 1ns/100ps
module fifo_port_and_irq_status_bench;
    import bfi_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic acc_start = 1'b0;
    logic [7:0] acc_addr = 8'h00;
    logic acc_valid = 1'b0;
    logic acc_write = 1'b0;
    logic [7:0] acc_wdata = 8'h00;
    logic [7:0] acc_rdata;
    logic acc_rdone;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_ready;
    logic [9:0] ev = 10'h000;
    logic cmd_force_idle;
    logic [6:0] status0;
    logic hi_live;
    logic lo_live;
    int bad_count = 0;
    int n_tests = 0;
    logic [7:0] r;
    logic f1;
    logic f2;
    int bitpos [10] = '{4, 4, 3, 2, 0, 1, 1, 1, 1, 1};

    always #5 clk = ~clk;

    bfi_core bfi_core_i (
        .clk(clk), .resetn(resetn), .acc_start(acc_start),
        .acc_addr(acc_addr), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_wdata(acc_wdata),
        .acc_rdata(acc_rdata), .acc_rdone(acc_rdone),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .cmd_self_done(ev[0]), .cmd_unknown(ev[1]),
        .cmd_force_idle(cmd_force_idle), .tx_last_bit(ev[2]),
        .rx_frame_end(ev[3]), .rx_frame_start(ev[4]),
        .buffer_write_fault(ev[5]), .buffer_overrun_fault(ev[6]),
        .protocol_fault(ev[7]), .missing_payload_fault(ev[8]),
        .integrity_fault(ev[9]), .interrupt_status_zero(status0),
        .high_threshold_live(hi_live), .low_threshold_live(lo_live)
    );

    bfi_rx_source bfi_rx_source_i (
        .clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data)
    );

    // ****************************************
    // Access tasks and comparison
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    task automatic go(input logic [7:0] a);
        @(negedge clk);
        acc_start = 1'b1;
        acc_addr = a;
        @(negedge clk);
        acc_start = 1'b0;
    endtask : go

    // Read data is only trusted in the cycle that rdone marks
    task automatic acc(input logic w, input logic [7:0] wd,
                       output logic [7:0] rd);
        int k;
        @(negedge clk);
        acc_valid = 1'b1;
        acc_write = w;
        acc_wdata = wd;
        @(negedge clk);
        acc_valid = 1'b0;
        rd = 8'h00;
        if (!w) begin
            for (k = 0; k < 4 && acc_rdone !== 1'b1; k++) @(negedge clk);
            rd = (acc_rdone === 1'b1) ? acc_rdata : 8'hxx;
        end
    endtask : acc

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        go(a);
        acc(1'b0, 8'h00, v);
        chk(v, exp);
    endtask : rchk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        go(a);
        acc(1'b1, d, v);
    endtask : wr

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        #100000;
        bad_count++;
        tally_and_finish;
    end

    initial begin
        repeat (4) @(negedge clk);
        chk({1'b0, status0}, 8'h00);
        resetn = 1'b1;
        rchk(ADDR_FILL, 8'h00);
        // Empty buffer keeps the low level live, so bit five latches
        rchk(ADDR_STATUS, 8'h20);
        rchk(8'h40, 8'h00);
        wr(ADDR_FILL, 8'h55);
        rchk(ADDR_FILL, 8'h00);
        $display("test reset done");

        wr(ADDR_STATUS, 8'hff);
        rchk(ADDR_STATUS, 8'h7f);
        wr(ADDR_STATUS, 8'h7f);
        rchk(ADDR_STATUS, 8'h20);
        wr(ADDR_STATUS, 8'h81);
        wr(ADDR_STATUS, 8'h80);
        rchk(ADDR_STATUS, 8'h21);
        wr(ADDR_STATUS, 8'h01);
        repeat (8) @(negedge clk);
        chk({1'b0, status0}, 8'h20);
        $display("test set clear done");

        // Event pulses one at a time, status cleared before each
        for (int k = 0; k < 10; k++) begin
            wr(ADDR_STATUS, 8'h7f);
            @(negedge clk);
            ev = 10'h001 << k;
            @(negedge clk);
            ev = 10'h000;
            f1 = cmd_force_idle;
            @(negedge clk);
            f2 = cmd_force_idle;
            r = 8'h20 | (8'h01 << bitpos[k]);
            chk({1'b0, status0}, r);
            chk({7'h00, f1 | f2}, {7'h00, k == 1});
            if (k == 3) begin
                // Receive done alone says nothing; host reads the fault bit
                rchk(ADDR_STATUS, 8'h24);
            end
        end
        wr(ADDR_STATUS, 8'h7f);
        rchk(ADDR_STATUS, 8'h20);
        $display("test events done");

        go(ADDR_DATA);
        acc(1'b1, 8'ha1, r);
        acc(1'b1, 8'hb2, r);
        acc(1'b1, 8'hc3, r);
        chk({7'h00, lo_live}, 8'h00);
        go(ADDR_FILL);
        acc(1'b0, 8'h00, r);
        chk(r, 8'h03);
        acc(1'b0, 8'h00, r);
        chk(r, 8'ha1);
        acc(1'b0, 8'h00, r);
        chk(r, 8'hb2);
        rchk(ADDR_FILL, 8'h01);
        wr(ADDR_CFG, 8'h10);
        rchk(ADDR_FILL, 8'h00);
        rchk(ADDR_CFG, 8'h20);
        $display("test data port done");

        go(ADDR_CFG);
        acc(1'b1, 8'h80, r);
        acc(1'b1, 8'hff, r);
        rchk(ADDR_CFG, 8'he0);
        go(ADDR_CFG);
        acc(1'b1, 8'h00, r);
        acc(1'b1, 8'h00, r);
        chk({7'h00, hi_live}, 8'h00);
        chk({1'b0, status0}, 8'h60);
        wr(ADDR_STATUS, 8'h7f);
        $display("test thresholds done");

        // Fill 512 plus 16 in the FIFO; the source then stalls
        fork
            bfi_rx_source_i.send(530);
        join_none
        for (int k = 0; k < 2000 && rx_ready !== 1'b0; k++) @(negedge clk);
        chk({7'h00, rx_ready}, 8'h00);
        // Low level bit was latched while the buffer was still empty
        chk({1'b0, status0}, 8'h60);
        // A write into the full buffer is dropped and flags a fault
        go(ADDR_DATA);
        acc(1'b1, 8'hee, r);
        chk({1'b0, status0}, 8'h62);
        rchk(ADDR_FILL, 8'h00);
        rchk(ADDR_CFG, 8'h42);
        go(ADDR_DATA);
        for (int i = 0; i < 530; i++) begin
            acc(1'b0, 8'h00, r);
            chk(r, i[7:0]);
        end
        rchk(ADDR_FILL, 8'h00);
        rchk(ADDR_CFG, 8'h20);
        $display("test fill drain done");

        // Reset in mid-run with a byte held and every flag set
        wr(ADDR_DATA, 8'h5a);
        wr(ADDR_STATUS, 8'hff);
        resetn = 1'b0;
        @(negedge clk);
        chk({1'b0, status0}, 8'h00);
        resetn = 1'b1;
        rchk(ADDR_FILL, 8'h00);
        $display("test mid reset done");
        tally_and_finish;
    end
endmodule : fifo_port_and_irq_status_bench
